//--- mrm_pkg.sv
// Purpose: shared constants for the mii/rmii mac port
// Assumes: reference clock of 250 MHz
// Notes:   mgmt clock rate is a plain default, change to taste
package mrm_pkg;
  localparam int REF_CLK_PERIOD_NS = 4;
  localparam int MGMT_PERIOD_NS    = 400;
  // least half period, rounded up to whole cycles
  localparam int MGMT_HALF_CYC     =
    (MGMT_PERIOD_NS / 2 + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int MGMT_FRAME_BITS   = 32;
  localparam int MGMT_CNT_W        = 6;
  localparam int NIBBLE_W          = 4;
  localparam int DIBIT_W           = 2;
  // synchroniser lanes
  localparam int SYNC_W            = 10;
  localparam int SYNC_TXCLK        = 0;
  localparam int SYNC_RXCLK        = 1;
  localparam int SYNC_RXD          = 2;
  localparam int SYNC_RXDV         = 6;
  localparam int SYNC_RXER         = 7;
  localparam int SYNC_COL          = 8;
  localparam int SYNC_CRS          = 9;
  localparam logic [NIBBLE_W-1:0] TX_IDLE_NIBBLE = 4'h0;
  typedef enum logic [1:0] {
    MRM_IDLE = 2'b00,
    MRM_LOW  = 2'b01,
    MRM_HIGH = 2'b10
  } mrm_mgmt_state_e;
endpackage

//--- mrm_mgmt_if.sv
// Purpose: command path between port top and management engine
// Assumes: single ref_clk_i domain
// Notes:   start is a one-cycle pulse, ignored while busy
`timescale 1ns/1ps
interface mrm_mgmt_if;
  logic        start;
  logic [31:0] wdata;
  logic [5:0]  drive_bits;
  logic        busy;
  logic        done;
  logic [31:0] rdata;
  modport ctrl (output start, wdata, drive_bits, input busy, done, rdata);
  modport engine (input start, wdata, drive_bits, output busy, done, rdata);
endinterface

//--- mrm_mgmt.sv
// Purpose: management clock generator and 32-bit serial shifter
// Assumes: first drive_bits bits driven, the rest sampled from the phy
// Notes:   data changes while the clock is low, sampled at its rise
`timescale 1ns/1ps
module mrm_mgmt
  import mrm_pkg::*;
#(
  parameter int HALF_CYC = MGMT_HALF_CYC
) (
  input  wire logic    ref_clk_i,
  input  wire logic    sys_rst_i,
  mrm_mgmt_if.engine   cmd,
  input  wire logic    mgmt_data_i,
  output logic         mgmt_clock_out_o,
  output logic         mgmt_data_o,
  output logic         mgmt_data_oe_o
);
  logic [1:0]            din_sync;
  mrm_mgmt_state_e       state;
  logic [7:0]            div;
  logic [MGMT_CNT_W-1:0] bit_idx;
  logic [31:0]           sh_out;
  logic [31:0]           sh_in;
  logic                  done;
  logic                  tick;

  assign tick      = (div == 8'(HALF_CYC - 1));
  assign cmd.busy  = (state != MRM_IDLE);
  assign cmd.done  = done;
  assign cmd.rdata = sh_in;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      din_sync <= 2'h0;
    end else begin
      din_sync <= {din_sync[0], mgmt_data_i};
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div <= 8'h00;
    end else if (state == MRM_IDLE || tick) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state            <= MRM_IDLE;
      bit_idx          <= '0;
      sh_out           <= 32'h0;
      sh_in            <= 32'h0;
      done             <= 1'b0;
      mgmt_clock_out_o <= 1'b0;
      mgmt_data_o      <= 1'b0;
      mgmt_data_oe_o   <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        MRM_IDLE: begin
          mgmt_clock_out_o <= 1'b0;
          if (cmd.start) begin
            state          <= MRM_LOW;
            bit_idx        <= '0;
            sh_out         <= cmd.wdata;
            mgmt_data_o    <= cmd.wdata[31];
            mgmt_data_oe_o <= (cmd.drive_bits != '0);
          end
        end
        MRM_LOW: begin
          if (tick) begin
            // both ends latch on this rising edge
            mgmt_clock_out_o <= 1'b1;
            sh_in            <= {sh_in[30:0], din_sync[1]};
            state            <= MRM_HIGH;
          end
        end
        MRM_HIGH: begin
          if (tick) begin
            mgmt_clock_out_o <= 1'b0;
            if (bit_idx == MGMT_CNT_W'(MGMT_FRAME_BITS - 1)) begin
              state          <= MRM_IDLE;
              done           <= 1'b1;
              mgmt_data_oe_o <= 1'b0;
            end else begin
              state          <= MRM_LOW;
              bit_idx        <= bit_idx + 1'b1;
              sh_out         <= {sh_out[30:0], 1'b0};
              mgmt_data_o    <= sh_out[30];
              mgmt_data_oe_o <= (bit_idx + 1'b1 < cmd.drive_bits);
            end
          end
        end
        default: begin
          state <= MRM_IDLE;
        end
      endcase
    end
  end

  default clocking mgmt_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  mgmt_data_edge_a: assert property (
    $changed(mgmt_data_o) |-> !mgmt_clock_out_o)
    else $error("mgmt data moved while clock high");
  mgmt_release_a: assert property (
    done |-> !mgmt_data_oe_o && !mgmt_clock_out_o)
    else $error("mgmt line not released at end");
  mgmt_start_a: assert property (
    cmd.start && !cmd.busy |=> cmd.busy && !mgmt_clock_out_o)
    else $error("mgmt start not taken");
endmodule

//--- mrm_port.sv
// What this block does
// - drive management clock; each data bit is latched on its rising edge.
// - management data pin is two-way; we drive it and release it.
// - mii transmit nibble changes off the transmit clock; phy samples on rise.
// - rmii transmits one dibit per reference clock on bus bits 1:0.
// - in mii drive transmit-active synchronous to the transmit clock.
// - rmii transmit-active rises with first nibble, holds for every dibit.
// - mii receive nibble is taken only while receive-valid is high.
// - rmii receives one dibit per reference clock on bus bits 1:0.
// - a receive error during a frame reports a crc error for it.
//
// Purpose: pin-level mii/rmii port toward an external phy
// Assumes: phy clocks are sampled by ref_clk_i, so 50 MHz rmii is marginal
// Notes:   user side works in nibbles; rmii sends low dibit first
`timescale 1ns/1ps
module mrm_port
  import mrm_pkg::*;
#(
  parameter int MGMT_HALF = MGMT_HALF_CYC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                rmii_mode_i,
  input  wire logic                tx_valid_i,
  input  wire logic [NIBBLE_W-1:0] tx_data_i,
  output logic                     tx_ready_o,
  output logic [NIBBLE_W-1:0]      rx_data_o,
  output logic                     rx_strobe_o,
  output logic                     rx_frame_o,
  output logic                     rx_crc_error_o,
  output logic                     collision_o,
  output logic                     carrier_o,
  input  wire logic                mgmt_start_i,
  input  wire logic [31:0]         mgmt_wdata_i,
  input  wire logic [5:0]          mgmt_drive_bits_i,
  output logic                     mgmt_busy_o,
  output logic                     mgmt_done_o,
  output logic [31:0]              mgmt_rdata_o,
  input  wire logic                tx_nibble_clock_i,
  output logic [NIBBLE_W-1:0]      tx_nibble_bus_o,
  output logic                     tx_active_o,
  input  wire logic                rx_nibble_clock_i,
  input  wire logic [NIBBLE_W-1:0] rx_nibble_bus_i,
  input  wire logic                rx_valid_i,
  input  wire logic                rx_error_in_i,
  input  wire logic                collision_in_i,
  input  wire logic                carrier_sense_in_i,
  output logic                     mgmt_clock_out_o,
  input  wire logic                mgmt_data_io_i,
  output logic                     mgmt_data_io_o,
  output logic                     mgmt_data_io_oe_o
);
  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;
  logic              tx_clk_prev;
  logic              rx_clk_prev;
  logic              tx_clk_src;
  logic              tx_edge;
  logic              rx_rise;
  logic              rx_valid_s;
  logic [1:0]        rx_dibit_s;
  logic              tx_phase;
  logic [1:0]        tx_high_dibit;
  logic              rx_pair;
  logic [1:0]        rx_low_dibit;
  logic              rx_err_seen;
  logic              rx_in_frame;

  mrm_mgmt_if mgmt_bus ();

  // data lanes ride the same two stages as the clocks to stay aligned
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {carrier_sense_in_i, collision_in_i, rx_error_in_i,
                   rx_valid_i, rx_nibble_bus_i, rx_nibble_clock_i,
                   tx_nibble_clock_i};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_clk_prev <= 1'b0;
      rx_clk_prev <= 1'b0;
    end else begin
      tx_clk_prev <= tx_clk_src;
      rx_clk_prev <= pin_sync[SYNC_RXCLK];
    end
  end

  // rmii takes its transmit timing from the shared reference pin
  assign tx_clk_src = rmii_mode_i ? pin_sync[SYNC_RXCLK]
                                  : pin_sync[SYNC_TXCLK];
  // update on the falling edge so outputs settle before the phy's rise
  assign tx_edge    = tx_clk_prev && !tx_clk_src;
  assign rx_rise    = !rx_clk_prev && pin_sync[SYNC_RXCLK];
  assign rx_valid_s = pin_sync[SYNC_RXDV];
  assign rx_dibit_s = pin_sync[SYNC_RXD +: DIBIT_W];

  // a nibble is taken only at a phase-0 edge in rmii
  assign tx_ready_o = tx_edge && tx_valid_i && !(rmii_mode_i && tx_phase);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_nibble_bus_o <= TX_IDLE_NIBBLE;
      tx_active_o     <= 1'b0;
      tx_phase        <= 1'b0;
      tx_high_dibit   <= 2'h0;
    end else if (tx_edge) begin
      if (rmii_mode_i && tx_phase) begin
        tx_nibble_bus_o <= {2'h0, tx_high_dibit};
        tx_phase        <= 1'b0;
      end else if (tx_valid_i) begin
        tx_active_o <= 1'b1;
        if (rmii_mode_i) begin
          tx_nibble_bus_o <= {2'h0, tx_data_i[1:0]};
          tx_high_dibit   <= tx_data_i[3:2];
          tx_phase        <= 1'b1;
        end else begin
          tx_nibble_bus_o <= tx_data_i;
        end
      end else begin
        tx_active_o     <= 1'b0;
        tx_nibble_bus_o <= TX_IDLE_NIBBLE;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_data_o    <= '0;
      rx_strobe_o  <= 1'b0;
      rx_pair      <= 1'b0;
      rx_low_dibit <= 2'h0;
    end else begin
      rx_strobe_o <= 1'b0;
      if (rx_rise) begin
        if (!rx_valid_s) begin
          // carrier drops only on nibble boundaries, so restart pairing
          rx_pair <= 1'b0;
        end else if (!rmii_mode_i) begin
          rx_data_o   <= pin_sync[SYNC_RXD +: NIBBLE_W];
          rx_strobe_o <= 1'b1;
        end else if (!rx_pair) begin
          rx_low_dibit <= rx_dibit_s;
          rx_pair      <= 1'b1;
        end else begin
          rx_data_o   <= {rx_dibit_s, rx_low_dibit};
          rx_strobe_o <= 1'b1;
          rx_pair     <= 1'b0;
        end
      end
    end
  end

  // frame ends on the sampled fall of valid or carrier/valid
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_in_frame    <= 1'b0;
      rx_err_seen    <= 1'b0;
      rx_crc_error_o <= 1'b0;
    end else begin
      rx_crc_error_o <= 1'b0;
      if (rx_rise) begin
        rx_in_frame <= rx_valid_s;
        if (rx_valid_s && pin_sync[SYNC_RXER]) begin
          rx_err_seen <= 1'b1;
        end else if (rx_in_frame && !rx_valid_s) begin
          rx_crc_error_o <= rx_err_seen;
          rx_err_seen    <= 1'b0;
        end
      end
    end
  end

  assign rx_frame_o  = rx_in_frame;
  // collision pin is pulled up and meaningless in rmii
  assign collision_o = !rmii_mode_i && pin_sync[SYNC_COL];
  assign carrier_o   = rmii_mode_i ? rx_valid_s : pin_sync[SYNC_CRS];

  assign mgmt_bus.start      = mgmt_start_i;
  assign mgmt_bus.wdata      = mgmt_wdata_i;
  assign mgmt_bus.drive_bits = mgmt_drive_bits_i;
  assign mgmt_busy_o         = mgmt_bus.busy;
  assign mgmt_done_o         = mgmt_bus.done;
  assign mgmt_rdata_o        = mgmt_bus.rdata;

  mrm_mgmt #(
    .HALF_CYC (MGMT_HALF)
  ) u_mgmt (
    .ref_clk_i        (ref_clk_i),
    .sys_rst_i        (sys_rst_i),
    .cmd              (mgmt_bus),
    .mgmt_data_i      (mgmt_data_io_i),
    .mgmt_clock_out_o (mgmt_clock_out_o),
    .mgmt_data_o      (mgmt_data_io_o),
    .mgmt_data_oe_o   (mgmt_data_io_oe_o)
  );

  default clocking port_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  tx_rmii_lanes_a: assert property (
    rmii_mode_i && $changed(tx_nibble_bus_o) |-> tx_nibble_bus_o[3:2] == 2'h0)
    else $error("rmii drove upper transmit bits");
  tx_bus_hold_a: assert property (
    !tx_edge |=> $stable(tx_nibble_bus_o) && $stable(tx_active_o))
    else $error("transmit pins moved off clock edge");
  tx_start_a: assert property (
    tx_ready_o && !tx_active_o |=> tx_active_o && tx_nibble_bus_o[1:0] ==
      $past(tx_data_i[1:0]))
    else $error("transmit-active missed first nibble");
  rx_valid_gate_a: assert property (
    rx_rise && !rx_valid_s |=> !rx_strobe_o)
    else $error("nibble taken without valid");
  rx_strobe_src_a: assert property (
    rx_strobe_o |-> $past(rx_rise) && $past(rx_valid_s))
    else $error("receive strobe without sampled edge");
  rx_pair_a: assert property (
    rmii_mode_i && rx_rise && rx_valid_s && !rx_pair |=> !rx_strobe_o ##0
      rx_pair)
    else $error("rmii nibble strobed after one dibit");
  rx_crc_err_a: assert property (
    rx_crc_error_o |-> $past(rx_err_seen) && !rx_in_frame)
    else $error("crc error without receive error");
  col_mode_a: assert property (
    rmii_mode_i |-> !collision_o)
    else $error("collision reported in rmii");
endmodule

//--- mrm_phy_model.sv
// Purpose: behavioural phy facing the mii/rmii port
// Assumes: one free 32 ns link clock serves tx clock and rmii reference
// Notes:   data changes on the falling link edge, stable at the rise
`timescale 1ns/1ps
module mrm_phy_model #(
  parameter logic [31:0] REPLY = 32'h5a3c_96e1
) (
  input  wire logic [3:0] tx_bus_i,
  input  wire logic       tx_active_i,
  input  wire logic       mdc_i,
  input  wire logic       mac_oe_i,
  output logic            tx_clk_o,
  output logic            rx_clk_o,
  output logic [3:0]      rx_bus_o,
  output logic            rx_valid_o,
  output logic            rx_err_o,
  output logic            mdio_o,
  output logic            mdio_oe_o
);
  logic       clk = 1'b0;
  logic [3:0] tx_q[$];
  int         k = 0;
  int         rises = 0;

  // odd offset keeps link edges off the 4 ns grid
  initial begin
    #5;
    forever #16 clk = ~clk;
  end
  assign tx_clk_o = clk;
  assign rx_clk_o = clk;

  // phy latches whatever the port presents while transmit is active
  always @(posedge clk) begin
    if (tx_active_i === 1'b1) tx_q.push_back(tx_bus_i);
  end

  // reply bit moves after each falling mgmt clock, so it holds past the rise
  // skip the unknown-to-low step at reset, or the reply slips one bit
  always @(negedge mdc_i) begin
    if (rises > 0) k++;
  end
  always @(posedge mdc_i) rises++;
  assign mdio_oe_o = !mac_oe_i;
  assign mdio_o    = REPLY[~k[4:0]];

  initial begin
    rx_bus_o   = 4'h0;
    rx_valid_o = 1'b0;
    rx_err_o   = 1'b0;
  end

  // rmii callers pass an even dibit count: valid drops on a nibble edge
  task automatic send(input logic [3:0] d[$], input bit err);
    foreach (d[i]) begin
      @(negedge clk);
      rx_bus_o   = d[i];
      rx_valid_o = 1'b1;
      rx_err_o   = err && i >= 1 && i <= 2; // two full clocks
    end
    @(negedge clk);
    rx_valid_o = 1'b0;
    rx_bus_o   = ~rx_bus_o;
    rx_err_o   = 1'b0;
  endtask
endmodule

//--- test_mii_rmii_mac_port.sv
// Purpose: self-checking bench for the mii/rmii port
// Assumes: mgmt half period shortened to 4 cycles
// Notes:   inputs change 1 ns after the rising ref clock
`timescale 1ns/1ps
module test_mii_rmii_mac_port;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rmii_mode_i = 1'b0;
  logic        tx_valid_i = 1'b0;
  logic [3:0]  tx_data_i = 4'h0;
  logic        collision_in_i = 1'b0;
  logic        carrier_sense_in_i = 1'b0;
  logic        mgmt_start_i = 1'b0;
  logic [31:0] mgmt_wdata_i = 32'h0;
  logic [5:0]  mgmt_drive_bits_i = 6'h0;
  logic        tx_ready_o, rx_strobe_o, rx_frame_o, rx_crc_error_o;
  logic        collision_o, carrier_o, mgmt_busy_o, mgmt_done_o;
  logic        tx_active_o, mgmt_clock_out_o, mgmt_data_io_o;
  logic        mgmt_data_io_oe_o, mgmt_data_io_i, mdio_phy, mdio_oe;
  logic        tx_nibble_clock_i, rx_nibble_clock_i, rx_valid_i;
  logic        rx_error_in_i;
  logic [3:0]  rx_data_o, tx_nibble_bus_o, rx_nibble_bus_i;
  logic [31:0] mgmt_rdata_o;
  logic [3:0]  rx_q[$];
  int          crc_n = 0;
  int          fr_bad = 0;
  int          n_fail = 0;
  int          tests_run = 0;

  always #2 ref_clk_i = ~ref_clk_i;
  // the phy only drives the mgmt line while the port has released it
  assign mgmt_data_io_i = mgmt_data_io_oe_o ? mgmt_data_io_o :
                          mdio_oe ? mdio_phy : 1'b1;

  mrm_port #(.MGMT_HALF(4)) DUT (
    .ref_clk_i, .sys_rst_i, .rmii_mode_i, .tx_valid_i, .tx_data_i,
    .tx_ready_o, .rx_data_o, .rx_strobe_o, .rx_frame_o, .rx_crc_error_o,
    .collision_o, .carrier_o, .mgmt_start_i, .mgmt_wdata_i,
    .mgmt_drive_bits_i, .mgmt_busy_o, .mgmt_done_o, .mgmt_rdata_o,
    .tx_nibble_clock_i, .tx_nibble_bus_o, .tx_active_o, .rx_nibble_clock_i,
    .rx_nibble_bus_i, .rx_valid_i, .rx_error_in_i, .collision_in_i,
    .carrier_sense_in_i, .mgmt_clock_out_o, .mgmt_data_io_i,
    .mgmt_data_io_o, .mgmt_data_io_oe_o
  );

  mrm_phy_model phy (
    .tx_bus_i(tx_nibble_bus_o), .tx_active_i(tx_active_o),
    .mdc_i(mgmt_clock_out_o), .mac_oe_i(mgmt_data_io_oe_o),
    .tx_clk_o(tx_nibble_clock_i), .rx_clk_o(rx_nibble_clock_i),
    .rx_bus_o(rx_nibble_bus_i), .rx_valid_o(rx_valid_i),
    .rx_err_o(rx_error_in_i), .mdio_o(mdio_phy), .mdio_oe_o(mdio_oe)
  );

  always @(posedge ref_clk_i) begin
    if (rx_strobe_o === 1'b1) rx_q.push_back(rx_data_o);
    if (rx_crc_error_o === 1'b1) crc_n++;
    if (rx_strobe_o === 1'b1 && rx_frame_o !== 1'b1) fr_bad++;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // valid held high across nibbles gives a back-to-back frame
  task automatic tx_frame(input logic [3:0] d[$]);
    int t;
    foreach (d[i]) begin
      tx_valid_i = 1'b1;
      tx_data_i  = d[i];
      t = 0;
      do begin
        @(posedge ref_clk_i);
        t++;
      end while (tx_ready_o !== 1'b1 && t < 200);
      if (tx_ready_o !== 1'b1) begin
        check("tx ready wait", 0, 1);
        final_report();
      end
      #1;
    end
    tx_valid_i = 1'b0;
    tick(40);
  endtask

  task automatic t_mii_tx();
    logic [3:0] d[$] = '{4'h5, 4'ha, 4'hf, 4'h0, 4'hc};
    phy.tx_q.delete();
    tx_frame(d);
    check("mii tx count", phy.tx_q.size(), 5);
    foreach (d[i]) check("mii tx nibble", phy.tx_q[i], d[i]);
    check("tx active idle", tx_active_o, 0);
  endtask

  task automatic t_rmii_tx();
    logic [3:0] d[$] = '{4'h6, 4'h9, 4'hd};
    phy.tx_q.delete();
    rmii_mode_i = 1'b1;
    tx_frame(d);
    check("rmii tx count", phy.tx_q.size(), 6);
    foreach (d[i]) begin
      check("rmii dibit lo", phy.tx_q[2*i], {2'b00, d[i][1:0]});
      check("rmii dibit hi", phy.tx_q[2*i+1], {2'b00, d[i][3:2]});
    end
    rmii_mode_i = 1'b0;
  endtask

  task automatic t_mii_rx();
    logic [3:0] d[$] = '{4'h3, 4'he, 4'h7, 4'h1};
    rx_q.delete();
    crc_n = 0;
    fr_bad = 0;
    phy.send(d, 1'b1);
    tick(20);
    check("rx frame during", fr_bad, 0);
    check("mii rx count", rx_q.size(), 4);
    foreach (d[i]) check("mii rx nibble", rx_q[i], d[i]);
    check("crc error", crc_n, 1);
    check("rx frame end", rx_frame_o, 0);
  endtask

  // upper pins carry junk that rmii must ignore
  task automatic t_rmii_rx();
    logic [3:0] d[$] = '{4'hd, 4'h6, 4'hb, 4'h8};
    rx_q.delete();
    crc_n = 0;
    rmii_mode_i = 1'b1;
    phy.send(d, 1'b0);
    tick(20);
    check("rmii rx count", rx_q.size(), 2);
    check("rmii rx nibble", rx_q[0], 4'h9);
    check("rmii rx nibble", rx_q[1], 4'h3);
    check("rmii no crc", crc_n, 0);
    rmii_mode_i = 1'b0;
  endtask

  task automatic t_mgmt(input logic [5:0] nd);
    logic [31:0] w;
    logic [31:0] m;
    int          r0;
    int          t;
    w = 32'hc3a5_0f96;
    m = ~(32'hffff_ffff >> nd);
    r0 = phy.rises;
    mgmt_wdata_i = w;
    mgmt_drive_bits_i = nd;
    mgmt_start_i = 1'b1;
    tick(1);
    mgmt_start_i = 1'b0;
    check("mgmt busy", mgmt_busy_o, 1);
    t = 0;
    while (mgmt_done_o !== 1'b1 && t < 400) begin
      @(posedge ref_clk_i);
      #1;
      t++;
    end
    check("mgmt done", mgmt_done_o, 1);
    if (mgmt_done_o !== 1'b1) final_report();
    tick(2);
    check("mgmt rdata", mgmt_rdata_o, (w & m) | (phy.REPLY & ~m));
    check("mgmt rises", phy.rises - r0, 32);
    check("mgmt released", mgmt_data_io_oe_o, 0);
  endtask

  task automatic t_status();
    collision_in_i = 1'b1;
    carrier_sense_in_i = 1'b1;
    tick(4);
    check("collision", collision_o, 1);
    check("carrier", carrier_o, 1);
    rmii_mode_i = 1'b1;
    tick(4);
    check("rmii collision", collision_o, 0);
    check("rmii carrier", carrier_o, 0);
    collision_in_i = 1'b0;
    rmii_mode_i = 1'b0;
    tick(4);
    check("collision end", collision_o, 0);
    carrier_sense_in_i = 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
    tick(2);
    t_mii_tx();
    t_rmii_tx();
    t_mii_rx();
    t_rmii_rx();
    t_mgmt(6'd0);
    t_mgmt(6'd14);
    t_mgmt(6'd32);
    t_status();
    final_report();
  end
endmodule
